// *** rtl/pci_top.sv ***
// Position command input: step train decoder and stored target selector
//
// Functional notes
// - Pulse type 0 quadrature x4, 1 CW/CCW, 2 step plus direction, others reserved
// - Slow path filter codes 0..3 give 600ns, 2.4us, 4.8us, 9.6us; 4 off
// - Fast path filter codes 0..3 give 150ns, 600ns, 1.2us, 2.4us; 4 off
// - Segments shorter than the minimum width merge into the surrounding level
// - Segments at or above the minimum width pass through unaltered
// - Polarity field: positive keeps levels, negative inverts step and direction
// - Source field 0 selects slow inputs, 1 selects fast inputs
// - Stored mode holds 64 targets of two words, chosen by selects and trigger
// - All selects active pick target one; all inactive pick target sixty-four
// - Only a rising trigger samples the selects and issues the target
// - Step inhibit in external step mode freezes the step count
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "pci_defs.svh"
module pci_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        slow_step_input,
    input  wire logic        slow_direction_input,
    input  wire logic        fast_step_input,
    input  wire logic        fast_direction_input,
    input  wire logic        step_inhibit,
    input  wire logic        target_select_bit0,
    input  wire logic        target_select_bit1,
    input  wire logic        target_select_bit2,
    input  wire logic        target_select_bit3,
    input  wire logic        target_select_bit4,
    input  wire logic        target_select_bit5,
    input  wire logic        target_trigger,
    output logic [31:0]      step_count,
    output logic [31:0]      target_position,
    output logic [31:0]      target_aux,
    output logic [5:0]       target_index,
    output logic             target_strobe
);
    logic                 setup;
    logic                 access;
    logic                 wr;
    logic [15:0]          cfg_r;
    logic [15:0]          cfg_nxt;
    pci_pkg::pci_mode_e   mode_r;
    pci_pkg::pci_mode_e   mode_nxt;
    logic [31:0]          prdata_r;
    logic [31:0]          prdata_nxt;
    logic                 rd_tbl_r;
    logic                 rd_tbl_nxt;
    logic [31:0]          count_r;
    logic [31:0]          count_nxt;
    pci_pkg::pci_line_s   prev_r;
    pci_pkg::pci_line_s   raw;
    pci_pkg::pci_line_s   filt;
    pci_pkg::pci_fetch_e  fetch_r;
    pci_pkg::pci_fetch_e  fetch_nxt;
    logic                 trig_prev_r;
    logic [5:0]           index_r;
    logic [5:0]           index_nxt;
    logic [31:0]          tpos_r;
    logic [31:0]          tpos_nxt;
    logic [31:0]          taux_r;
    logic [31:0]          taux_nxt;
    logic                 tstrobe_r;
    logic                 tstrobe_nxt;
    logic [3:0]           ptype;
    logic [3:0]           filt_code;
    logic                 fast_sel;
    logic                 pol_neg;
    pci_pkg::pci_width_t  min_cyc;
    logic [5:0]           sel_idx;
    logic                 trig_rise;
    logic                 ext_ok;
    logic [31:0]          mem_rdata;
    pci_pkg::pci_target_s pair;

    function automatic logic tbl_hit(input logic [11:0] a);
        tbl_hit = (a >= `PCI_TBL_FIRST) && (a <= `PCI_TBL_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = tbl_hit(a) || a == `PCI_CTRL_OFS || a == `PCI_STAT_OFS ||
                 a == `PCI_COUNT_OFS || a == `PCI_TPOS_OFS || a == `PCI_TAUX_OFS ||
                 a == `PCI_CFG_OFS;
    endfunction

    // +1 for a step-leads transition, -1 for step-lags, 0 otherwise
    function automatic logic [31:0] quad_step(input logic [3:0] t);
        case (t)
            4'h2, 4'hB, 4'hD, 4'h4: quad_step = 32'h00000001;
            4'h1, 4'h7, 4'hE, 4'h8: quad_step = 32'hFFFFFFFF;
            default:                quad_step = 32'h00000000;
        endcase
    endfunction

    function automatic pci_pkg::pci_width_t width_cyc(input logic fast, input logic [3:0] c);
        width_cyc = '0;
        if (fast)
        begin
            case (c)
                4'h0:    width_cyc = 11'(`PCI_NS2CYC(`PCI_HS0_NS));
                4'h1:    width_cyc = 11'(`PCI_NS2CYC(`PCI_HS1_NS));
                4'h2:    width_cyc = 11'(`PCI_NS2CYC(`PCI_HS2_NS));
                4'h3:    width_cyc = 11'(`PCI_NS2CYC(`PCI_HS3_NS));
                default: width_cyc = '0;
            endcase
        end
        else
        begin
            case (c)
                4'h0:    width_cyc = 11'(`PCI_NS2CYC(`PCI_LS0_NS));
                4'h1:    width_cyc = 11'(`PCI_NS2CYC(`PCI_LS1_NS));
                4'h2:    width_cyc = 11'(`PCI_NS2CYC(`PCI_LS2_NS));
                4'h3:    width_cyc = 11'(`PCI_NS2CYC(`PCI_LS3_NS));
                default: width_cyc = '0;
            endcase
        end
    endfunction

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr     = access && pwrite;

    // Field extraction from the configuration word
    assign ptype     = cfg_r[`PCI_CFG_TYPE_LSB +: 4];
    assign filt_code = cfg_r[`PCI_CFG_FILT_LSB +: 4];
    assign pol_neg   = cfg_r[`PCI_CFG_POL_LSB +: 4] == `PCI_POL_NEG;
    assign fast_sel  = cfg_r[`PCI_CFG_SRC_LSB +: 4] == `PCI_SRC_FAST;
    assign min_cyc   = width_cyc(fast_sel, filt_code);

    // Source select, then polarity, then the width filter
    always_comb
    begin
        if (fast_sel)
            raw = {fast_step_input, fast_direction_input};
        else
            raw = {slow_step_input, slow_direction_input};
        if (pol_neg)
            raw = ~raw;
    end

    for (genvar i = 0; i < 2; i++)
    begin : g_filt
        pci_step_filter u_filt (
            .pclk    (pclk),
            .presetn (presetn),
            .din     (raw[i]),
            .min_cyc (min_cyc),
            .dout    (filt[i])
        );
    end

    // Register file; every access completes without wait states
    always_comb
    begin
        cfg_nxt    = cfg_r;
        mode_nxt   = mode_r;
        prdata_nxt = prdata_r;
        rd_tbl_nxt = rd_tbl_r;
        if (wr && paddr == `PCI_CFG_OFS)
        begin
            if (pstrb[0])
                cfg_nxt[7:0] = pwdata[7:0];
            if (pstrb[1])
                cfg_nxt[15:8] = pwdata[15:8];
        end
        else if (wr && paddr == `PCI_CTRL_OFS && pstrb[0])
            mode_nxt = pci_pkg::pci_mode_e'(pwdata[`PCI_CTRL_MODE_BIT]);
        if (setup)
        begin
            rd_tbl_nxt = tbl_hit(paddr);
            prdata_nxt = '0;
            if (paddr == `PCI_CTRL_OFS)
                prdata_nxt[`PCI_CTRL_MODE_BIT] = mode_r;
            else if (paddr == `PCI_STAT_OFS)
                prdata_nxt[10:0] = {index_r, fetch_r, filt, step_inhibit, mode_r};
            else if (paddr == `PCI_COUNT_OFS)
                prdata_nxt = count_r;
            else if (paddr == `PCI_TPOS_OFS)
                prdata_nxt = tpos_r;
            else if (paddr == `PCI_TAUX_OFS)
                prdata_nxt = taux_r;
            else if (paddr == `PCI_CFG_OFS)
                prdata_nxt[15:0] = cfg_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r    <= `PCI_CFG_RST;
            mode_r   <= pci_pkg::PCI_EXT_STEP;
            prdata_r <= '0;
            rd_tbl_r <= 1'b0;
        end
        else
        begin
            cfg_r    <= cfg_nxt;
            mode_r   <= mode_nxt;
            prdata_r <= prdata_nxt;
            rd_tbl_r <= rd_tbl_nxt;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = access && !mapped(paddr);
    assign prdata  = rd_tbl_r ? mem_rdata : prdata_r;

    // Step counting; a clear from software overrides a step in the same cycle
    assign ext_ok = mode_r == pci_pkg::PCI_EXT_STEP && !step_inhibit;
    always_comb
    begin
        count_nxt = count_r;
        if (ext_ok)
        begin
            case (ptype)
                `PCI_TYPE_QUAD: count_nxt = count_r + quad_step({prev_r, filt});
                `PCI_TYPE_CWCCW:
                begin
                    if (filt.step && !prev_r.step)
                        count_nxt = count_nxt + 32'h00000001;
                    if (filt.dir && !prev_r.dir)
                        count_nxt = count_nxt - 32'h00000001;
                end
                `PCI_TYPE_PDIR:
                begin
                    if (filt.step && !prev_r.step)
                        count_nxt = filt.dir ? count_r - 32'h00000001 : count_r + 32'h00000001;
                end
                default: count_nxt = count_r;
            endcase
        end
        if (wr && paddr == `PCI_CTRL_OFS && pstrb[0] && pwdata[`PCI_CTRL_CLR_BIT])
            count_nxt = '0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r <= '0;
            prev_r  <= '0;
        end
        else
        begin
            count_r <= count_nxt;
            prev_r  <= filt;
        end
    end

    // Stored target fetch: the pair is read at the trigger edge, issued two cycles after the edge
    assign sel_idx   = ~{target_select_bit5, target_select_bit4, target_select_bit3,
                         target_select_bit2, target_select_bit1, target_select_bit0};
    assign trig_rise = target_trigger && !trig_prev_r;

    always_comb
    begin
        fetch_nxt   = fetch_r;
        index_nxt   = index_r;
        tpos_nxt    = tpos_r;
        taux_nxt    = taux_r;
        tstrobe_nxt = 1'b0;
        case (fetch_r)
            pci_pkg::PCI_FETCH_IDLE: ;
            pci_pkg::PCI_FETCH_LOAD:
            begin
                tpos_nxt    = pair.pos;
                taux_nxt    = pair.aux;
                tstrobe_nxt = 1'b1;
                fetch_nxt   = pci_pkg::PCI_FETCH_IDLE;
            end
            default: fetch_nxt = pci_pkg::PCI_FETCH_IDLE;
        endcase
        if (trig_rise && mode_r == pci_pkg::PCI_STORED)
        begin
            fetch_nxt = pci_pkg::PCI_FETCH_LOAD;
            index_nxt = sel_idx;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fetch_r     <= pci_pkg::PCI_FETCH_IDLE;
            trig_prev_r <= 1'b0;
            index_r     <= '0;
            tpos_r      <= '0;
            taux_r      <= '0;
            tstrobe_r   <= 1'b0;
        end
        else
        begin
            fetch_r     <= fetch_nxt;
            trig_prev_r <= target_trigger;
            index_r     <= index_nxt;
            tpos_r      <= tpos_nxt;
            taux_r      <= taux_nxt;
            tstrobe_r   <= tstrobe_nxt;
        end
    end

    pci_target_mem u_mem (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (wr && tbl_hit(paddr)),
        .wr_be     (pstrb),
        .wr_addr   (paddr[8:2]),
        .wr_data   (pwdata),
        .rd_addr   (paddr[8:2]),
        .rd_data   (mem_rdata),
        .pair_idx  (sel_idx),
        .pair_data (pair)
    );

    assign step_count      = count_r;
    assign target_position = tpos_r;
    assign target_aux      = taux_r;
    assign target_index    = index_r;
    assign target_strobe   = tstrobe_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence trig_edge_s;
        trig_rise && mode_r == pci_pkg::PCI_STORED;
    endsequence

    cfg_write_a: assert property ((wr && paddr == `PCI_CFG_OFS && pstrb[1:0] == 2'h3)
        |=> (ptype == $past(pwdata[3:0]) && fast_sel == ($past(pwdata[15:12]) == 4'h1)))
        else $error("configuration fields misplaced");
    inhibit_hold_a: assert property ((step_inhibit && mode_r == pci_pkg::PCI_EXT_STEP && !wr)
        |=> $stable(count_r))
        else $error("count moved while inhibited");
    reserved_type_a: assert property ((ptype > `PCI_TYPE_PDIR && !wr) |=> $stable(count_r))
        else $error("count moved in reserved format");
    trig_issue_a: assert property (trig_edge_s |-> ##2 target_strobe)
        else $error("target not issued two cycles after trigger");
    strobe_cause_a: assert property (target_strobe |-> $past(trig_rise, 2))
        else $error("target issued without trigger edge");
    sel_decode_a: assert property (trig_edge_s |=> target_index == ~$past({target_select_bit5,
        target_select_bit4, target_select_bit3, target_select_bit2, target_select_bit1,
        target_select_bit0}))
        else $error("wrong target index");
    quad_up_a: assert property ((ext_ok && ptype == `PCI_TYPE_QUAD && prev_r == 2'b00
        && filt == 2'b10 && !wr) |=> count_r == $past(count_r) + 32'h00000001)
        else $error("quadrature lead not counted up");
    polarity_a: assert property ((pol_neg && !fast_sel)
        |-> raw == ~{slow_step_input, slow_direction_input})
        else $error("polarity not applied");
    source_a: assert property ((fast_sel && !pol_neg)
        |-> raw == {fast_step_input, fast_direction_input})
        else $error("fast source not selected");
    width_slow_a: assert property ((!fast_sel && filt_code == 4'h3) |-> min_cyc == 11'd1920)
        else $error("slow filter width wrong");
    width_fast_a: assert property ((fast_sel && filt_code == 4'h0) |-> min_cyc == 11'd30)
        else $error("fast filter width wrong");
endmodule

// *** rtl/pci_defs.svh ***
// Constants of the position command input block
`ifndef PCI_DEFS_SVH
`define PCI_DEFS_SVH

// Register byte offsets
`define PCI_CTRL_OFS      12'h000
`define PCI_STAT_OFS      12'h004
`define PCI_COUNT_OFS     12'h008
`define PCI_TPOS_OFS      12'h00C
`define PCI_TAUX_OFS      12'h010
`define PCI_CFG_OFS       12'h100
`define PCI_TBL_FIRST     12'h400
`define PCI_TBL_LAST      12'h5FC

// Reset values
`define PCI_CFG_RST       16'h0002
`define PCI_CTRL_RST      1'h0

// Control bits
`define PCI_CTRL_MODE_BIT 0
`define PCI_CTRL_CLR_BIT  1

// Configuration word field positions
`define PCI_CFG_TYPE_LSB  0
`define PCI_CFG_FILT_LSB  4
`define PCI_CFG_POL_LSB   8
`define PCI_CFG_SRC_LSB   12

// Field encodings
`define PCI_TYPE_QUAD     4'h0
`define PCI_TYPE_CWCCW    4'h1
`define PCI_TYPE_PDIR     4'h2
`define PCI_FILT_NONE     4'h4
`define PCI_POL_NEG       4'h1
`define PCI_SRC_FAST      4'h1

// Clock period and minimum accepted widths
`define PCI_CLK_NS        5
`define PCI_LS0_NS        600
`define PCI_LS1_NS        2400
`define PCI_LS2_NS        4800
`define PCI_LS3_NS        9600
`define PCI_HS0_NS        150
`define PCI_HS1_NS        600
`define PCI_HS2_NS        1200
`define PCI_HS3_NS        2400
`define PCI_NS2CYC(t)     (((t) + `PCI_CLK_NS - 1) / `PCI_CLK_NS)

`endif

// *** rtl/pci_pkg.sv ***
// Types of the position command input block
package pci_pkg;
    typedef enum logic {PCI_EXT_STEP, PCI_STORED} pci_mode_e;
    typedef enum logic {PCI_FETCH_IDLE, PCI_FETCH_LOAD} pci_fetch_e;
    typedef logic [10:0] pci_width_t;
    typedef struct packed {
        logic step;
        logic dir;
    } pci_line_s;
    typedef struct packed {
        logic [31:0] aux;
        logic [31:0] pos;
    } pci_target_s;
endpackage

// *** rtl/pci_step_filter.sv ***
// Minimum width filter for one step or direction line
`timescale 1ns/10ps
module pci_step_filter (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              din,
    input  wire pci_pkg::pci_width_t min_cyc,
    output logic                   dout
);
    pci_pkg::pci_width_t cnt_r;
    pci_pkg::pci_width_t cnt_nxt;
    logic                dout_r;
    logic                dout_nxt;

    // A level must persist min_cyc cycles before it is passed on
    always_comb
    begin
        cnt_nxt  = '0;
        dout_nxt = dout_r;
        if (min_cyc == '0)
            dout_nxt = din;
        else if (din != dout_r)
        begin
            if (cnt_r == min_cyc - 11'h001)
                dout_nxt = din;
            else
                cnt_nxt = cnt_r + 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r  <= '0;
            dout_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            dout_r <= dout_nxt;
        end
    end

    assign dout = dout_r;

    filter_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        (min_cyc == '0) |=> (dout == $past(din)))
        else $error("unfiltered line did not follow input");
    filter_short_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($changed(dout) && $past(min_cyc) != '0) |-> ($past(cnt_r) == $past(min_cyc) - 11'h001))
        else $error("filtered line changed before minimum width");
endmodule

// *** rtl/pci_target_mem.sv ***
// Table of 64 stored targets, two words each, with registered reads
`timescale 1ns/10ps
module pci_target_mem (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              wr_en,
    input  wire logic [3:0]        wr_be,
    input  wire logic [6:0]        wr_addr,
    input  wire logic [31:0]       wr_data,
    input  wire logic [6:0]        rd_addr,
    output logic [31:0]            rd_data,
    input  wire logic [5:0]        pair_idx,
    output pci_pkg::pci_target_s   pair_data
);
    logic [31:0]          mem [128];
    logic [31:0]          rd_data_r;
    pci_pkg::pci_target_s pair_r;

    // Byte lanes written separately so partial bus writes need no read-back;
    // one process owns the whole array, as a variable index spans every word
    always_ff @(posedge pclk)
    begin
        for (int b = 0; b < 4; b++)
        begin
            if (wr_en && wr_be[b])
                mem[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
        end
    end

    // Even word is the position, odd word the companion word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data_r <= '0;
            pair_r    <= '0;
        end
        else
        begin
            rd_data_r  <= mem[rd_addr];
            pair_r.pos <= mem[{pair_idx, 1'b0}];
            pair_r.aux <= mem[{pair_idx, 1'b1}];
        end
    end

    assign rd_data   = rd_data_r;
    assign pair_data = pair_r;

    pair_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && wr_be == 4'hF && wr_addr == {pair_idx, 1'b0}) ##1 (pair_idx == $past(pair_idx))
        |=> (pair_data.pos == $past(wr_data, 2)))
        else $error("stored target word not returned");
endmodule

// *** tb/pci_host.sv ***
// Host motion controller model driving step, direction and select lines
`timescale 1ns/10ps
module pci_host (
    input  wire logic        pclk,
    input  wire logic        neg,
    input  wire logic        fast,
    output logic             slow_s,
    output logic             slow_d,
    output logic             fast_s,
    output logic             fast_d,
    output logic [5:0]       sel,
    output logic             trig
);
    logic l_s;
    logic l_d;
    initial
    begin
        l_s = 1'b0;
        l_d = 1'b0;
        sel = 6'h3F;
        trig = 1'b0;
    end
    // Idle path repeats the steps with reversed direction, so a wrong path choice miscounts
    assign fast_s = l_s ^ neg;
    assign slow_s = l_s ^ neg;
    assign fast_d = l_d ^ neg ^ ~fast;
    assign slow_d = l_d ^ neg ^ fast;
    task automatic drive(input logic s, input logic d, input int hold);
        l_s <= s;
        l_d <= d;
        repeat (hold) @(posedge pclk);
    endtask
    // Level times of 25 fast or 250 slow cycles stay below the slowest legal width of each path
    task automatic step(input logic s, input logic d);
        drive(s, d, fast ? 25 : 250);
    endtask
    task automatic trigger(input logic [5:0] s);
        sel <= s;
        @(posedge pclk);
        trig <= 1'b1;
        @(posedge pclk);
        trig <= 1'b0;
        sel <= ~s;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the position command input block
`timescale 1ns/10ps
`include "pci_defs.svh"
module testbench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ss, sd, fs, fd, trig, tstb, rerr;
    logic        inh;
    logic        neg;
    logic        fast;
    logic [5:0]  sel, tidx, k;
    logic [31:0] cnt, tpos, taux, rdat, exp_cnt, tw;
    int          err_count;
    int          compares;
    int          cyc;
    int          n;
    int          ls[4] = '{`PCI_LS0_NS, `PCI_LS1_NS, `PCI_LS2_NS, `PCI_LS3_NS};
    int          hs[4] = '{`PCI_HS0_NS, `PCI_HS1_NS, `PCI_HS2_NS, `PCI_HS3_NS};

    pci_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_step_input(ss), .slow_direction_input(sd),
        .fast_step_input(fs), .fast_direction_input(fd), .step_inhibit(inh),
        .target_select_bit0(sel[0]), .target_select_bit1(sel[1]),
        .target_select_bit2(sel[2]), .target_select_bit3(sel[3]),
        .target_select_bit4(sel[4]), .target_select_bit5(sel[5]),
        .target_trigger(trig), .step_count(cnt), .target_position(tpos),
        .target_aux(taux), .target_index(tidx), .target_strobe(tstb));
    pci_host u_host (.pclk(pclk), .neg(neg), .fast(fast), .slow_s(ss), .slow_d(sd),
        .fast_s(fs), .fast_d(fd), .sel(sel), .trig(trig));

    always #2.5 pclk = ~pclk;

    task automatic wrap_up();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            err_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Count change for one move of the logical lines, tr = old step, old dir, new step, new dir
    function automatic logic [31:0] move_gain(input logic [3:0] ty, input logic [3:0] tr);
        case (ty)
            `PCI_TYPE_QUAD: return ((tr[3] != tr[1]) == (tr[1] ^ tr[0])) ? 32'h1 : 32'hFFFFFFFF;
            `PCI_TYPE_CWCCW: return (!tr[3] && tr[1]) ? 32'h1 : ((!tr[2] && tr[0]) ? 32'hFFFFFFFF : 32'h0);
            `PCI_TYPE_PDIR: return (!tr[3] && tr[1]) ? (tr[0] ? 32'hFFFFFFFF : 32'h1) : 32'h0;
            default: return 32'h0;
        endcase
    endfunction

    task automatic cfg_walk(input logic [3:0] ty, input logic p, input logic sr);
        logic s;
        logic d;
        logic f;
        neg <= p;
        fast <= sr;
        u_host.step(1'b0, 1'b0);
        // Unfiltered setting suits the fastest legal trains
        apb(1'b1, `PCI_CFG_OFS, {19'h0, sr, 3'h0, p, `PCI_FILT_NONE, ty});
        apb(1'b1, `PCI_CTRL_OFS, 32'h2);
        exp_cnt = 32'h0;
        s = 1'b0;
        d = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            f = 1'($urandom_range(1));
            if (inh !== 1'b1)
                exp_cnt = exp_cnt + move_gain(ty, {s, d, s ^ f, d ^ ~f});
            s = s ^ f;
            d = d ^ ~f;
            u_host.step(s, d);
        end
        repeat (4) @(posedge pclk);
        chk(cnt, exp_cnt);
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        inh = 1'b0;
        neg = 1'b0;
        fast = 1'b0;
        err_count = 0;
        compares = 0;
        cyc = 0;
        n = $urandom(32'h9478);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PCI_CFG_OFS, 32'h0);
        chk(rdat, {16'h0, `PCI_CFG_RST});
        apb(1'b1, `PCI_CFG_OFS, 32'hABCD1234);
        apb(1'b0, `PCI_CFG_OFS, 32'h0);
        chk(rdat, 32'h00001234);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        for (int p = 0; p < 2; p++)
            for (int sr = 0; sr < 2; sr++)
                for (int ty = 0; ty < 4; ty++)
                    cfg_walk(4'(ty), p[0], sr[0]);
        inh <= 1'b1;
        cfg_walk(`PCI_TYPE_PDIR, 1'b0, 1'b1);
        inh <= 1'b0;
        // Boundary widths: one cycle short is merged, exactly the minimum is kept
        for (int sr = 0; sr < 2; sr++)
            for (int c = 0; c < 4; c++)
            begin
                n = `PCI_NS2CYC(sr ? hs[c] : ls[c]);
                fast <= sr[0];
                u_host.drive(1'b0, 1'b0, 5);
                apb(1'b1, `PCI_CFG_OFS, {19'h0, sr[0], 4'h0, 4'(c), `PCI_TYPE_PDIR});
                apb(1'b1, `PCI_CTRL_OFS, 32'h2);
                u_host.drive(1'b1, 1'b0, n - 1);
                u_host.drive(1'b0, 1'b0, 2 * n);
                u_host.drive(1'b1, 1'b0, n);
                u_host.drive(1'b0, 1'b0, n - 1);
                u_host.drive(1'b1, 1'b0, n);
                u_host.drive(1'b0, 1'b0, 2 * n);
                u_host.drive(1'b1, 1'b0, n);
                u_host.drive(1'b0, 1'b0, 2 * n);
                chk(cnt, 32'h2);
            end
        apb(1'b1, `PCI_CTRL_OFS, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            k = (i == 0) ? 6'h00 : (i == 1) ? 6'h01 : (i == 2) ? 6'h3F : 6'($urandom);
            tw = $urandom;
            apb(1'b1, 12'(`PCI_TBL_FIRST + 8 * k), tw);
            apb(1'b1, 12'(`PCI_TBL_FIRST + 8 * k + 4), ~tw);
            apb(1'b0, 12'(`PCI_TBL_FIRST + 8 * k), 32'h0);
            chk(rdat, tw);
            u_host.trigger(~k);
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (tstb !== 1'b1 && n < 8);
            chk(tpos, tw);
            chk(taux, ~tw);
            chk({26'h0, tidx}, {26'h0, k});
            repeat (4) @(posedge pclk);
            chk({25'h0, tstb, tidx}, {26'h0, k});
        end
        wrap_up();
    end
endmodule
